//--- src/logic_tile_datapath.sv
// programmable logic tile datapath with byte queues, status/control and ahb-lite slave
//
// The address map and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module logic_tile_datapath (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [5:0] route_in,
	output logic [5:0] route_out,
	input wire logic [7:0] status_in,
	output logic [7:0] ctrl_out,
	input wire logic chain_carry_in,
	input wire logic chain_shift_in,
	input wire logic chain_zero_in,
	output logic chain_carry_out,
	output logic chain_shift_out,
	output logic chain_zero_out,
	output logic irq
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		tile_pkg::bus_e bus_state;
		logic [7:0] addr;
		logic wr;
		logic [31:0] rdata;
		logic [7:0][15:0] cfg;
		logic [1:0][3:0][7:0] work;
		logic carry_reg;
		logic shift_reg;
		logic set_sel;
		logic [1:0][3:0][7:0] qmem;
		logic [1:0][1:0] qrd;
		logic [1:0][1:0] qwr;
		logic [1:0][2:0] qcnt;
		logic [12:0] mode;
		logic [5:0][3:0] out_sel;
		logic [7:0] control;
		logic [7:0] sticky_mask;
		logic [7:0] sticky;
		logic [7:0] poly;
		logic [tile_pkg::irq_w-1:0] irq_stat;
		logic [tile_pkg::irq_w-1:0] irq_mask;
	} state_s;

	state_s state_reg;
	state_s state_next;

	// ****************************************
	// datapath combinational
	// ****************************************
	logic [15:0] cw;
	logic set;
	logic [2:0] msb;
	logic [7:0] mask;
	logic [7:0] opa;
	logic [7:0] opb;
	logic [7:0] opb_eff;
	logic cin;
	logic cin_eff;
	logic sin;
	logic [8:0] sum9;
	logic [7:0] alu_res;
	logic alu_carry;
	logic [7:0] result;
	logic shout;
	logic crc_fb;
	logic [3:0] carry_idx;
	logic cmp_eq;
	logic cmp_lt;
	logic zero_det;
	logic ones_det;
	logic [1:0] q_empty;
	logic [1:0] q_full;
	logic [15:0] cond;
	logic [7:0] status_view;

	assign cw = state_reg.cfg[route_in[2:0]];
	assign set = state_reg.mode[tile_pkg::mode_tmux_bit] & state_reg.set_sel;
	assign msb = state_reg.mode[tile_pkg::mode_msb_lsb +: 3];
	assign mask = 8'hff >> (3'h7 - msb);
	assign carry_idx = {1'b0, msb} + 4'h1;
	assign opa = state_reg.work[set][cw[tile_pkg::cw_srca_lsb +: 2]] & mask;
	assign opb = state_reg.work[set][cw[tile_pkg::cw_srcb_lsb +: 2]] & mask;

	// carry sources: zero, registered, neighbour, routing; serial sources: routing, registered, neighbour, zero
	always_comb begin
		case (state_reg.mode[tile_pkg::mode_cin_lsb +: 2])
			2'h1: cin = state_reg.carry_reg;
			2'h2: cin = chain_carry_in;
			2'h3: cin = route_in[4];
			default: cin = 1'b0;
		endcase
		case (state_reg.mode[tile_pkg::mode_sin_lsb +: 2])
			2'h1: sin = state_reg.shift_reg;
			2'h2: sin = chain_shift_in;
			2'h3: sin = 1'b0;
			default: sin = route_in[3];
		endcase
	end

	always_comb begin
		opb_eff = opb;
		cin_eff = cin;
		alu_res = 8'h00;
		case (tile_pkg::alu_op_e'(cw[tile_pkg::cw_op_lsb +: 3]))
			tile_pkg::op_inc: begin
				opb_eff = 8'h00;
				cin_eff = 1'b1;
			end
			tile_pkg::op_dec: begin
				opb_eff = mask;
				cin_eff = 1'b0;
			end
			tile_pkg::op_sub: begin
				opb_eff = ~opb & mask;
				cin_eff = 1'b1;
			end
			default: begin
				opb_eff = opb;
			end
		endcase
		sum9 = {1'b0, opa} + {1'b0, opb_eff} + {8'h00, cin_eff};
		case (tile_pkg::alu_op_e'(cw[tile_pkg::cw_op_lsb +: 3]))
			tile_pkg::op_pass: alu_res = opa;
			tile_pkg::op_and: alu_res = opa & opb;
			tile_pkg::op_or: alu_res = opa | opb;
			tile_pkg::op_xor: alu_res = opa ^ opb;
			default: alu_res = sum9[7:0] & mask;
		endcase
		alu_carry = sum9[carry_idx];
	end

	// shifter, with the crc step taking over when selected
	always_comb begin
		crc_fb = opa[msb] ^ sin;
		result = alu_res;
		shout = 1'b0;
		if (cw[tile_pkg::cw_crc_bit]) begin
			result = ((opa << 1) & mask) ^ (crc_fb ? (state_reg.poly & mask) : 8'h00);
			shout = crc_fb;
		end else begin
			case (cw[tile_pkg::cw_shift_lsb +: 2])
				2'h1: begin
					result = ((alu_res << 1) | {7'h00, sin}) & mask;
					shout = alu_res[msb];
				end
				2'h2: begin
					result = (alu_res >> 1) | ({7'h00, sin} << msb);
					shout = alu_res[0];
				end
				2'h3: result = {alu_res[3:0], alu_res[7:4]};
				default: result = alu_res;
			endcase
		end
	end

	assign cmp_eq = (opa == opb) & (~state_reg.mode[tile_pkg::mode_chain_bit] | chain_zero_in);
	assign cmp_lt = opa < opb;
	assign zero_det = (result == 8'h00) & (~state_reg.mode[tile_pkg::mode_chain_bit] | chain_zero_in);
	assign ones_det = result == mask;
	assign chain_carry_out = alu_carry;
	assign chain_shift_out = shout;
	assign chain_zero_out = zero_det;

	generate
		for (genvar q = 0; q < 2; q++) begin : g_qflag
			assign q_empty[q] = state_reg.qcnt[q] == 3'h0;
			assign q_full[q] = state_reg.qcnt[q] == 3'(tile_pkg::queue_depth);
		end
	endgenerate

	assign cond = {1'b1, 1'b0, result[msb], state_reg.set_sel, q_full[1], q_empty[1], q_full[0],
		q_empty[0], state_reg.shift_reg, state_reg.carry_reg, shout, alu_carry, ones_det, zero_det,
		cmp_lt, cmp_eq};

	generate
		for (genvar o = 0; o < tile_pkg::route_w; o++) begin : g_route
			assign route_out[o] = cond[state_reg.out_sel[o]];
		end
	endgenerate

	assign status_view = (state_reg.sticky_mask & state_reg.sticky) |
		(~state_reg.sticky_mask & status_in);

	// ****************************************
	// next state
	// ****************************************
	logic [1:0] push;
	logic [1:0] pop;
	logic [1:0][7:0] push_data;
	logic [1:0] refused;
	logic [7:0] sticky_set;
	logic step;
	logic qs;
	logic [7:0] load_val;

	always_comb begin
		state_next = state_reg;
		push = 2'b00;
		pop = 2'b00;
		push_data = '0;
		refused = 2'b00;
		step = route_in[5] & state_reg.mode[tile_pkg::mode_dp_run_bit];
		qs = cw[tile_pkg::cw_qsel_bit];
		load_val = result;
		sticky_set = 8'h00;

		// datapath step: one configuration per enabled cycle
		if (step) begin
			state_next.carry_reg = alu_carry;
			state_next.shift_reg = shout;
			if (state_reg.mode[tile_pkg::mode_tmux_bit]) begin
				state_next.set_sel = ~state_reg.set_sel;
			end
			if (cw[tile_pkg::cw_qload_bit] && !state_reg.mode[qs]) begin
				load_val = state_reg.qmem[qs][state_reg.qrd[qs]];
				if (q_empty[qs]) begin
					refused[qs] = 1'b1;
				end else begin
					pop[qs] = 1'b1;
				end
			end
			if (cw[tile_pkg::cw_qstore_bit] && state_reg.mode[qs]) begin
				if (q_full[qs]) begin
					refused[qs] = 1'b1;
				end else begin
					push[qs] = 1'b1;
					push_data[qs] = result;
				end
			end
			// a refused queue load still writes the stale head into the destination
			if (cw[tile_pkg::cw_write_bit]) begin
				state_next.work[set][{1'b0, cw[tile_pkg::cw_dest_bit]}] = load_val;
			end
		end

		// bus slave: address phase taken, one wait cycle, then answer
		state_next.bus_state = tile_pkg::bus_idle;
		if (state_reg.bus_state == tile_pkg::bus_idle) begin
			if (hsel && htrans[1] && hready) begin
				state_next.bus_state = tile_pkg::bus_wait;
				state_next.addr = {haddr[7:2], 2'b00};
				state_next.wr = hwrite;
			end
		end else begin
			state_next.rdata = 32'h0000_0000;
			if (state_reg.addr <= tile_pkg::cfg_store_end) begin
				if (state_reg.wr) begin
					state_next.cfg[state_reg.addr[4:2]] = hwdata[15:0];
				end
				state_next.rdata = {16'h0000, state_reg.cfg[state_reg.addr[4:2]]};
			end else if (state_reg.addr >= tile_pkg::work_set0_base &&
					state_reg.addr <= tile_pkg::work_set0_end) begin
				if (state_reg.wr) begin
					state_next.work[0][state_reg.addr[3:2]] = hwdata[7:0];
				end
				state_next.rdata = {24'h000000, state_reg.work[0][state_reg.addr[3:2]]};
			end else if (state_reg.addr >= tile_pkg::work_set1_base &&
					state_reg.addr <= tile_pkg::work_set1_end) begin
				if (state_reg.wr) begin
					state_next.work[1][state_reg.addr[3:2]] = hwdata[7:0];
				end
				state_next.rdata = {24'h000000, state_reg.work[1][state_reg.addr[3:2]]};
			end else if (state_reg.addr == tile_pkg::queue0_ofs ||
					state_reg.addr == tile_pkg::queue1_ofs) begin
				if (state_reg.wr && !state_reg.mode[state_reg.addr[2]]) begin
					if (q_full[state_reg.addr[2]]) begin
						refused[state_reg.addr[2]] = 1'b1;
					end else begin
						push[state_reg.addr[2]] = 1'b1;
						push_data[state_reg.addr[2]] = hwdata[7:0];
					end
				end else if (!state_reg.wr && state_reg.mode[state_reg.addr[2]]) begin
					if (q_empty[state_reg.addr[2]]) begin
						refused[state_reg.addr[2]] = 1'b1;
					end else begin
						pop[state_reg.addr[2]] = 1'b1;
						state_next.rdata = {24'h000000,
							state_reg.qmem[state_reg.addr[2]][state_reg.qrd[state_reg.addr[2]]]};
					end
				end
			end else if (state_reg.addr == tile_pkg::mode_ofs) begin
				if (state_reg.wr) begin
					state_next.mode = hwdata[12:0];
				end
				state_next.rdata = {19'h00000, state_reg.mode};
			end else if (state_reg.addr == tile_pkg::out_sel_ofs) begin
				if (state_reg.wr) begin
					state_next.out_sel = hwdata[23:0];
				end
				state_next.rdata = {8'h00, state_reg.out_sel};
			end else if (state_reg.addr == tile_pkg::control_ofs) begin
				if (state_reg.wr) begin
					state_next.control = hwdata[7:0];
				end
				state_next.rdata = {24'h000000, state_reg.control};
			end else if (state_reg.addr == tile_pkg::status_ofs) begin
				if (!state_reg.wr) begin
					state_next.rdata = {24'h000000, status_view};
					state_next.sticky = 8'h00;
				end
			end else if (state_reg.addr == tile_pkg::sticky_mask_ofs) begin
				if (state_reg.wr) begin
					state_next.sticky_mask = hwdata[7:0];
				end
				state_next.rdata = {24'h000000, state_reg.sticky_mask};
			end else if (state_reg.addr == tile_pkg::polynomial_ofs) begin
				if (state_reg.wr) begin
					state_next.poly = hwdata[7:0];
				end
				state_next.rdata = {24'h000000, state_reg.poly};
			end else if (state_reg.addr == tile_pkg::irq_status_ofs) begin
				if (!state_reg.wr) begin
					state_next.rdata = {29'h00000000, state_reg.irq_stat};
					state_next.irq_stat = '0;
				end
			end else if (state_reg.addr == tile_pkg::irq_mask_ofs) begin
				if (state_reg.wr) begin
					state_next.irq_mask = hwdata[tile_pkg::irq_w-1:0];
				end
				state_next.rdata = {29'h00000000, state_reg.irq_mask};
			end else if (state_reg.addr == tile_pkg::queue_level_ofs) begin
				state_next.rdata = {20'h00000, q_full, q_empty, 1'b0, state_reg.qcnt[1], 1'b0,
					state_reg.qcnt[0]};
			end
		end

		// queue pointers; push and pop in one cycle keep the level
		for (int q = 0; q < 2; q++) begin
			if (push[q]) begin
				state_next.qmem[q][state_reg.qwr[q]] = push_data[q];
				state_next.qwr[q] = state_reg.qwr[q] + 2'h1;
			end
			if (pop[q]) begin
				state_next.qrd[q] = state_reg.qrd[q] + 2'h1;
			end
			state_next.qcnt[q] = state_reg.qcnt[q] + {2'b00, push[q]} - {2'b00, pop[q]};
		end

		// sticky capture after the read clear, so a same-cycle pulse survives
		if (state_reg.mode[tile_pkg::mode_sc_run_bit]) begin
			sticky_set = state_reg.sticky_mask & status_in & ~state_next.sticky;
		end
		state_next.sticky = state_next.sticky | sticky_set;
		state_next.irq_stat = state_next.irq_stat | {|sticky_set, refused};
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= '0;
			state_reg.bus_state <= tile_pkg::bus_idle;
			state_reg.mode <= tile_pkg::mode_reset;
		end else begin
			state_reg <= state_next;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign hreadyout = state_reg.bus_state == tile_pkg::bus_idle;
	assign hresp = 1'b0;
	assign hrdata = state_reg.rdata;
	assign ctrl_out = state_reg.control;
	assign irq = |(state_reg.irq_stat & state_reg.irq_mask);

endmodule

//--- src/tile_pkg.sv
// constants, types and register map of the logic tile datapath block
package tile_pkg;

	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [7:0] cfg_store_base = 8'h00;
	localparam logic [7:0] cfg_store_end = 8'h1c;
	localparam logic [7:0] work_set0_base = 8'h20;
	localparam logic [7:0] work_set0_end = 8'h2c;
	localparam logic [7:0] queue0_ofs = 8'h30;
	localparam logic [7:0] queue1_ofs = 8'h34;
	localparam logic [7:0] mode_ofs = 8'h38;
	localparam logic [7:0] out_sel_ofs = 8'h3c;
	localparam logic [7:0] control_ofs = 8'h40;
	localparam logic [7:0] status_ofs = 8'h44;
	localparam logic [7:0] sticky_mask_ofs = 8'h48;
	localparam logic [7:0] polynomial_ofs = 8'h4c;
	localparam logic [7:0] irq_status_ofs = 8'h50;
	localparam logic [7:0] irq_mask_ofs = 8'h54;
	localparam logic [7:0] queue_level_ofs = 8'h58;
	localparam logic [7:0] work_set1_base = 8'h60;
	localparam logic [7:0] work_set1_end = 8'h6c;

	// ****************************************
	// mode register fields
	// ****************************************
	localparam int mode_q0_out_bit = 0;
	localparam int mode_q1_out_bit = 1;
	localparam int mode_msb_lsb = 2;
	localparam int mode_cin_lsb = 5;
	localparam int mode_sin_lsb = 7;
	localparam int mode_chain_bit = 9;
	localparam int mode_tmux_bit = 10;
	localparam int mode_dp_run_bit = 11;
	localparam int mode_sc_run_bit = 12;
	localparam logic [12:0] mode_reset = 13'h181c;

	// ****************************************
	// configuration word fields
	// ****************************************
	localparam int cw_op_lsb = 0;
	localparam int cw_srca_lsb = 3;
	localparam int cw_srcb_lsb = 5;
	localparam int cw_shift_lsb = 7;
	localparam int cw_dest_bit = 9;
	localparam int cw_write_bit = 10;
	localparam int cw_crc_bit = 11;
	localparam int cw_qload_bit = 12;
	localparam int cw_qstore_bit = 13;
	localparam int cw_qsel_bit = 14;

	// ****************************************
	// interrupt events and sizes
	// ****************************************
	localparam int ev_q0_refused = 0;
	localparam int ev_q1_refused = 1;
	localparam int ev_sticky = 2;
	localparam int irq_w = 3;
	localparam int queue_depth = 4;
	localparam int route_w = 6;

	typedef enum logic [1:0] {bus_idle = 2'b01, bus_wait = 2'b10} bus_e;
	typedef enum logic [2:0] {op_pass, op_inc, op_dec, op_add, op_sub, op_and, op_or,
		op_xor} alu_op_e;

endpackage

//--- tb/routing_partner.sv
// routing matrix and neighbour datapath model facing the tile's routing side
`timescale 1ns/1ps
module routing_partner (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic step,
	input wire logic [2:0] cfg_addr,
	input wire logic [7:0] events,
	output logic [5:0] route_in,
	output logic [7:0] status_in,
	output logic chain_carry_in,
	output logic chain_shift_in,
	output logic chain_zero_in
);
	// neighbour is idle: nothing carried or shifted in
	assign chain_carry_in = 1'b0;
	assign chain_shift_in = 1'b0;
	assign chain_zero_in = 1'b0;
	// registered so requests reach the tile like any routed flop output
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			route_in <= 6'h00;
			status_in <= 8'h00;
		end else begin
			route_in <= {step, 2'b00, cfg_addr};
			status_in <= events;
		end
	end
endmodule

//--- tb/testbench.sv
// self-checking bench for the logic tile datapath over its bus and routing
`timescale 1ns/1ps
module testbench;
	logic hclk;
	logic hresetn;
	logic hsel;
	logic hwrite;
	logic hreadyout;
	logic hresp;
	logic irq;
	logic step;
	logic chain_carry_in;
	logic chain_shift_in;
	logic chain_zero_in;
	logic chain_carry_out;
	logic chain_shift_out;
	logic chain_zero_out;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [1:0] htrans;
	logic [5:0] route_in;
	logic [5:0] route_out;
	logic [7:0] status_in;
	logic [7:0] ctrl_out;
	logic [7:0] events;
	logic [2:0] cfg_addr;
	int fail_count;
	int samples_checked;

	logic_tile_datapath i_logic_tile_datapath (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'b010), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .route_in,
		.route_out, .status_in, .ctrl_out, .chain_carry_in, .chain_shift_in, .chain_zero_in,
		.chain_carry_out, .chain_shift_out, .chain_zero_out, .irq);
	routing_partner i_routing_partner (.hclk, .hresetn, .step, .cfg_addr, .events, .route_in,
		.status_in, .chain_carry_in, .chain_shift_in, .chain_zero_in);

	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	// ****************************************
	// reporting
	// ****************************************
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("unexpected %s expected %h seen %h", what, exp, got);
			fail_count++;
		end
	endtask

	// ****************************************
	// bus and routing drivers
	// ****************************************
	// sampling at the falling edge sees what the next rising edge will sample
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		n = 0;
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h0, a};
		do begin
			@(negedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		@(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do begin
			@(negedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		r = hrdata;
		@(posedge hclk);
		if (n >= 20) begin
			fail_count++;
			summarize();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, a, d, r);
	endtask

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		xfer(1'b0, a, 32'h0, r);
		check(what, exp, r);
	endtask

	task automatic run(input logic [2:0] a, input int n);
		step <= 1'b1;
		cfg_addr <= a;
		repeat (n) @(posedge hclk);
		step <= 1'b0;
		repeat (2) @(posedge hclk);
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		htrans = 2'b00;
		hwrite = 1'b0;
		haddr = 32'h0;
		hwdata = 32'h0;
		step = 1'b0;
		cfg_addr = 3'h0;
		events = 8'h00;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd_chk("mode", tile_pkg::mode_ofs, 32'h181c);
		rd_chk("unmapped", 8'h70, 32'h0);
		wr(tile_pkg::control_ofs, 32'ha5);
		check("control out", 32'ha5, {24'h0, ctrl_out});
		wr(tile_pkg::irq_mask_ofs, 32'h7);
		for (int i = 0; i < 5; i++) begin
			wr(tile_pkg::queue0_ofs, 32'h10 + i);
		end
		rd_chk("level full", tile_pkg::queue_level_ofs, 32'h604);
		check("irq on refusal", 32'h1, {31'h0, irq});
		rd_chk("irq status", tile_pkg::irq_status_ofs, 32'h1);
		check("irq cleared", 32'h0, {31'h0, irq});
		wr(tile_pkg::out_sel_ofs, 32'h89);
		check("route full", 32'h1, {26'h0, route_out[1:0]});
		// word 1 pops queue 0 into a0, word 2 increments a0
		wr(tile_pkg::cfg_store_base + 8'h04, 32'h1400);
		wr(tile_pkg::cfg_store_base + 8'h08, 32'h0401);
		run(3'h1, 4);
		rd_chk("a0 popped", tile_pkg::work_set0_base, 32'h13);
		check("route empty", 32'h2, {26'h0, route_out[1:0]});
		run(3'h2, 1);
		rd_chk("a0 inc", tile_pkg::work_set0_base, 32'h14);
		run(3'h1, 1);
		rd_chk("empty pop", tile_pkg::irq_status_ofs, 32'h1);
		// word 3 is one crc step on a0
		wr(tile_pkg::polynomial_ofs, 32'h07);
		wr(tile_pkg::cfg_store_base + 8'h0c, 32'h0c00);
		wr(tile_pkg::work_set0_base, 32'h94);
		run(3'h3, 1);
		rd_chk("crc 8 bit", tile_pkg::work_set0_base, 32'h2f);
		wr(tile_pkg::mode_ofs, 32'h180c);
		wr(tile_pkg::work_set0_base, 32'h0c);
		run(3'h3, 1);
		rd_chk("crc 4 bit", tile_pkg::work_set0_base, 32'h0f);
		// next feedback bit: a0 bit 3 set, serial in low
		check("crc shift out", 32'h1, {31'h0, chain_shift_out});
		wr(tile_pkg::sticky_mask_ofs, 32'h1);
		events <= 8'h01;
		@(posedge hclk);
		events <= 8'h00;
		repeat (3) @(posedge hclk);
		check("irq sticky", 32'h1, {31'h0, irq});
		rd_chk("status set", tile_pkg::status_ofs, 32'h1);
		rd_chk("status clear", tile_pkg::status_ofs, 32'h0);
		rd_chk("irq sticky bit", tile_pkg::irq_status_ofs, 32'h4);
		// inc of a0 at full width leaves the registered carry clear
		wr(tile_pkg::mode_ofs, 32'h181c);
		run(3'h2, 1);
		// sixteen-bit add: low byte in set 0, its carry feeds set 1 on the next step
		wr(tile_pkg::work_set0_base, 32'hf0);
		wr(tile_pkg::work_set0_base + 8'h08, 32'h20);
		wr(tile_pkg::work_set1_base, 32'h01);
		wr(tile_pkg::work_set1_base + 8'h08, 32'h02);
		wr(tile_pkg::cfg_store_base + 8'h10, 32'h0443);
		wr(tile_pkg::mode_ofs, 32'h1c3c);
		run(3'h4, 2);
		rd_chk("low byte", tile_pkg::work_set0_base, 32'h10);
		rd_chk("high byte", tile_pkg::work_set1_base, 32'h04);
		// e0 plus 20 wraps to zero with a carry out
		wr(tile_pkg::work_set0_base, 32'he0);
		check("chain carry", 32'h1, {31'h0, chain_carry_out});
		check("chain zero", 32'h1, {31'h0, chain_zero_out});
		wr(tile_pkg::mode_ofs, 32'h1e3c);
		check("chain zero gated", 32'h0, {31'h0, chain_zero_out});
		summarize();
	end
endmodule

//--- tb/tile_checker_assertions.sv
// bus and interrupt timing checks bound to the logic tile datapath
`timescale 1ns/1ps
module tile_checker (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic [5:0] route_in,
	input wire logic [7:0] status_in,
	input wire logic [7:0] ctrl_out,
	input wire logic irq
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// ****************************************
	// bus handshake
	// ****************************************
	sequence s_taken;
		hsel && htrans[1] && hready && hreadyout;
	endsequence
	sequence s_one_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	a_wait_one: assert property (s_taken |=> s_one_wait)
		else $error("transfer not answered after one wait");
	a_no_stall: assert property (!hreadyout |=> hreadyout)
		else $error("wait state longer than one cycle");
	a_idle_ready: assert property (hreadyout && !(hsel && htrans[1]) |=> hreadyout)
		else $error("wait state without a transfer");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("error response given");
	a_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
		else $error("read data moved outside a transfer");
	// ****************************************
	// control and interrupt
	// ****************************************
	a_ctrl_bus: assert property ($changed(ctrl_out) |-> !$past(hreadyout))
		else $error("control bits changed without a bus write");
	a_irq_rise: assert property ($rose(irq) |->
		!$past(hreadyout) || $past(route_in[5]) || $past(status_in) != 8'h00)
		else $error("interrupt raised without a cause");
	a_irq_fall: assert property ($fell(irq) |-> !$past(hreadyout))
		else $error("interrupt dropped without a bus access");
endmodule
bind logic_tile_datapath tile_checker i_tile_checker (.hclk, .hresetn, .hsel, .htrans, .hready,
	.hreadyout, .hresp, .hrdata, .route_in, .status_in, .ctrl_out, .irq);
